// ==== chan_link_if.sv ====
`timescale 1ns/10ps
interface chan_link_if;
  logic [15:0] count;
  logic        wr;
  logic [15:0] wdata;
  logic        tick;
  logic        down;
  modport cnt (output count, input wr, input wdata, input tick, input down);
  modport cmp (input count);
endinterface

// ==== channel_counter_unit.sv ====
`timescale 1ns/10ps
module channel_counter_unit #(
  parameter bit UPDOWN = 1'b0
) (
  input  wire logic  hclk,     // bus clock
  input  wire logic  hresetn,  // async reset, low
  chan_link_if.cnt   lnk       // counter side of channel link
);
  logic [15:0] count_ff;
  logic [15:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (lnk.wr) begin
      nxt_count = lnk.wdata;
    end else if (lnk.tick) begin
      if (UPDOWN && lnk.down) begin
        nxt_count = count_ff - 16'h0001;
      end else begin
        nxt_count = count_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= tmr_pkg::COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign lnk.count = count_ff;

  chk_no_down: assert property (@(posedge hclk) disable iff (!hresetn)
    (!UPDOWN && $past(lnk.tick) && !$past(lnk.wr)) |-> count_ff == $past(count_ff) + 16'h0001)
    else $error("fixed up-counter did not step up");
endmodule

// ==== compare_unit.sv ====
`timescale 1ns/10ps
module compare_unit #(
  parameter int NREG = 4
) (
  input  wire logic        hclk,          // bus clock
  input  wire logic        hresetn,       // async reset, low
  chan_link_if.cmp         lnk,           // counter value
  input  wire logic [3:0]  capture_mode,  // 1: input capture, 0: compare
  input  wire logic [1:0]  buffer_en,     // c buffers a, d buffers b
  input  wire logic [3:0]  capture_in,    // capture strobes
  input  wire logic [3:0]  wr_en,         // bus write per register
  input  wire logic [15:0] wdata,         // bus write data
  output logic      [63:0] greg,          // register values, a lowest
  output logic      [3:0]  hit            // match or capture event
);
  logic [15:0] greg_ff [4];
  logic [15:0] nxt_greg [4];
  logic [3:0]  eq_ff;
  logic [3:0]  nxt_eq;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_greg[i] = greg_ff[i];
      nxt_eq[i]   = 1'b0;
      hit[i]      = 1'b0;
    end
    for (int i = 0; i < NREG; i++) begin
      nxt_eq[i] = (lnk.count == greg_ff[i]);
      if (wr_en[i]) begin
        nxt_greg[i] = wdata;
      end
    end
    for (int i = 0; i < NREG; i++) begin
      if (capture_mode[i] && capture_in[i]) begin
        hit[i]      = 1'b1;
        nxt_greg[i] = lnk.count;
        if (NREG == 4 && i < 2 && buffer_en[i % 2]) begin
          nxt_greg[(i + 2) % 4] = greg_ff[i];
        end
      end else if (!capture_mode[i] && nxt_eq[i] && !eq_ff[i]) begin
        hit[i] = 1'b1;
        if (NREG == 4 && i < 2 && buffer_en[i % 2]) begin
          nxt_greg[i] = greg_ff[(i + 2) % 4];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        greg_ff[i] <= tmr_pkg::GREG_RST;
      end
      eq_ff <= 4'h0;
    end else begin
      greg_ff <= nxt_greg;
      eq_ff   <= nxt_eq;
    end
  end

  assign greg = {greg_ff[3], greg_ff[2], greg_ff[1], greg_ff[0]};

  chk_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    (capture_mode[0] && capture_in[0]) |=> greg_ff[0] == $past(lnk.count))
    else $error("capture did not copy the counter");
endmodule

// ==== tb_timer_capture_compare_core.sv ====
`timescale 1ns/10ps
module tb_timer_capture_compare_core;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [5:0]  count_tick = 6'h00;
  logic [5:0]  count_down = 6'h00;
  logic [23:0] capture_in = 24'h000000;
  logic [23:0] xfer_ack;
  logic [23:0] irq_disable_select;
  logic [23:0] arm = 24'h000000;
  logic [23:0] select_cfg = 24'h000000;
  logic [23:0] match_irq;
  logic        irq;
  logic        seen_req = 1'b0;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #10 hclk = ~hclk;

  timer_capture_compare_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick),
    .count_down(count_down), .capture_in(capture_in), .xfer_ack(xfer_ack),
    .irq_disable_select(irq_disable_select), .match_irq(match_irq), .irq(irq));

  xfer_ctl_model xfer_u (.hclk(hclk), .hresetn(hresetn), .match_irq(match_irq), .arm(arm),
    .select_cfg(select_cfg), .xfer_ack(xfer_ack), .irq_disable_select(irq_disable_select));

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (match_irq[13] === 1'b1) seen_req <= 1'b1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ad(input int ch, input logic [4:0] ofs);
    return 32'(ch * 32) + 32'(ofs);
  endfunction

  // entered just after a rising edge; every wait ends on sampled hreadyout
  task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, tmr_pkg::HSIZE_WORD, d, v);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(a, 1'b0, tmr_pkg::HSIZE_WORD, 32'h00000000, v);
    check(v, exp);
  endtask

  task automatic tick(input logic [5:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      count_tick <= m;
      @(posedge hclk);
      count_tick <= 6'h00;
      repeat (2) @(posedge hclk);
    end
  endtask

  task automatic t_reset_values();
    for (int ch = 0; ch < 6; ch++) begin
      rdc(ad(ch, tmr_pkg::OFS_COUNT), 32'h00000000);
      rdc(ad(ch, tmr_pkg::OFS_GREG_A), 32'h0000FFFF);
      rdc(ad(ch, tmr_pkg::OFS_GREG_B), 32'h0000FFFF);
      rdc(ad(ch, tmr_pkg::OFS_STATUS), 32'h000000C0);
    end
    rdc(ad(3, tmr_pkg::OFS_GREG_D), 32'h0000FFFF);
    rdc(32'h000000D0, 32'h00000000);
  endtask

  task automatic t_compare_clear_irq();
    wr(ad(1, tmr_pkg::OFS_GREG_A), 32'h00000005);
    wr(ad(1, tmr_pkg::OFS_COUNT), 32'h00000003);
    wr(ad(1, tmr_pkg::OFS_CTRL), 32'h00000400);
    tick(6'h02, 2);
    wr(ad(1, tmr_pkg::OFS_STATUS), 32'h00000000);
    rdc(ad(1, tmr_pkg::OFS_STATUS), 32'h000000C1);
    wr(ad(1, tmr_pkg::OFS_STATUS), 32'h00000000);
    rdc(ad(1, tmr_pkg::OFS_STATUS), 32'h000000C0);
    rdc({24'h0, tmr_pkg::OFS_IRQ_ST}, 32'h00000010);
    check({31'h0, irq}, 32'h00000000);
    wr({24'h0, tmr_pkg::OFS_IRQ_MASK}, 32'h00000010);
    check({31'h0, irq}, 32'h00000001);
    wr({24'h0, tmr_pkg::OFS_IRQ_ST}, 32'h00000010);
    check({31'h0, irq}, 32'h00000000);
    rdc({24'h0, tmr_pkg::OFS_IRQ_ST}, 32'h00000000);
  endtask

  task automatic t_capture_buffer();
    wr(ad(0, tmr_pkg::OFS_GREG_A), 32'h000000AB);
    wr(ad(0, tmr_pkg::OFS_CTRL), 32'h00000011);
    wr(ad(0, tmr_pkg::OFS_COUNT), 32'h00001234);
    capture_in <= 24'h000001;
    @(posedge hclk);
    capture_in <= 24'h000000;
    repeat (2) @(posedge hclk);
    rdc(ad(0, tmr_pkg::OFS_GREG_A), 32'h00001234);
    rdc(ad(0, tmr_pkg::OFS_GREG_C), 32'h000000AB);
    rdc(ad(0, tmr_pkg::OFS_STATUS), 32'h000000C1);
  endtask

  task automatic t_word_only();
    logic [31:0] v;
    bus(ad(2, tmr_pkg::OFS_COUNT), 1'b1, 3'h0, 32'h000000AA, v);
    bus(ad(2, tmr_pkg::OFS_GREG_A), 1'b1, 3'h1, 32'h00000055, v);
    rdc(ad(2, tmr_pkg::OFS_COUNT), 32'h00000000);
    rdc(ad(2, tmr_pkg::OFS_GREG_A), 32'h0000FFFF);
    bus(ad(0, tmr_pkg::OFS_COUNT), 1'b0, 3'h1, 32'h00000000, v);
    check(v, 32'h00000000);
    check({31'h0, hresp}, 32'h00000000);
  endtask

  task automatic t_reserved_flags();
    wr(ad(2, tmr_pkg::OFS_CTRL), 32'h0000000F);
    capture_in <= 24'h000F00;
    @(posedge hclk);
    capture_in <= 24'h000000;
    repeat (2) @(posedge hclk);
    rdc(ad(2, tmr_pkg::OFS_STATUS), 32'h000000C3);
    rdc(ad(2, tmr_pkg::OFS_GREG_C), 32'h00000000);
    // capture lands in the data phase of the clearing write
    fork
      wr(ad(2, tmr_pkg::OFS_STATUS), 32'h00000000);
      begin
        @(posedge hclk);
        capture_in <= 24'h000100;
        @(posedge hclk);
        capture_in <= 24'h000000;
      end
    join
    rdc(ad(2, tmr_pkg::OFS_STATUS), 32'h000000C1);
  endtask

  task automatic t_transfer_clear();
    arm       <= 24'h010000 | 24'h002000;
    select_cfg <= 24'h010000;
    wr(ad(3, tmr_pkg::OFS_GREG_B), 32'h00000002);
    wr(ad(3, tmr_pkg::OFS_CTRL), 32'h00000480);
    wr(ad(4, tmr_pkg::OFS_GREG_A), 32'h00000002);
    wr(ad(4, tmr_pkg::OFS_CTRL), 32'h00000440);
    tick(6'h18, 2);
    repeat (4) @(posedge hclk);
    check({31'h0, seen_req}, 32'h00000001);
    rdc(ad(3, tmr_pkg::OFS_STATUS), 32'h000000C0);
    rdc(ad(4, tmr_pkg::OFS_STATUS), 32'h000000C1);
    check({8'h0, match_irq & 24'h010000}, 32'h00010000);
  endtask

  task automatic t_direction();
    logic [31:0] v;
    count_down <= 6'h3F;
    wr(ad(0, tmr_pkg::OFS_GREG_A), 32'h00000012);
    wr(ad(0, tmr_pkg::OFS_COUNT), 32'h00000010);
    wr(ad(0, tmr_pkg::OFS_CTRL), 32'h00000C10);
    wr(ad(5, tmr_pkg::OFS_COUNT), 32'h00000010);
    wr(ad(5, tmr_pkg::OFS_CTRL), 32'h00000C00);
    wr(ad(2, tmr_pkg::OFS_COUNT), 32'h00000010);
    wr(ad(2, tmr_pkg::OFS_CTRL), 32'h00000400);
    tick(6'h25, 3);
    rdc(ad(0, tmr_pkg::OFS_COUNT), 32'h00000013);
    rdc(ad(0, tmr_pkg::OFS_GREG_A), 32'h000000AB);
    rdc(ad(5, tmr_pkg::OFS_COUNT), 32'h0000000D);
    rdc(ad(2, tmr_pkg::OFS_COUNT), 32'h00000013);
    bus(ad(5, tmr_pkg::OFS_STATUS), 1'b0, 3'h0, 32'h00000000, v);
    check(v & 32'h00000080, 32'h00000000);
    count_down <= 6'h00;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_compare_clear_irq();
    t_capture_buffer();
    t_word_only();
    t_reserved_flags();
    t_transfer_clear();
    t_direction();
    report_and_stop();
  end
endmodule

// ==== timer_capture_compare_core.sv ====
`timescale 1ns/10ps
module timer_capture_compare_core (
  input  wire logic        hclk,        // bus clock
  input  wire logic        hresetn,     // async reset, low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write when high
  input  wire logic [2:0]  hsize,       // transfer size
  input  wire logic [31:0] hwdata,      // write data
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // transfer done
  output logic             hresp,       // always okay
  input  wire logic [5:0]  count_tick,  // count pulse per channel
  input  wire logic [5:0]  count_down,  // phase/cascade direction
  input  wire logic [23:0] capture_in,  // capture strobes, ch*4+reg
  input  wire logic [23:0] xfer_ack,    // transfer controller start
  input  wire logic [23:0] irq_disable_select,  // controller's irq disable select
  output logic      [23:0] match_irq,   // per-flag requests
  output logic             irq          // masked event interrupt
);
  tmr_pkg::bus_state_type state_ff, nxt_state;
  logic [7:0]  addr_ff, nxt_addr;
  logic        write_ff, nxt_write;
  logic        word_ff, nxt_word;
  logic        ready_ff, nxt_ready;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [11:0] ctl_ff [6];
  logic [11:0] nxt_ctl [6];
  logic [23:0] flag_ff, nxt_flag;
  logic [23:0] armed_ff, nxt_armed;
  logic [23:0] irq_st_ff, nxt_irq_st;
  logic [23:0] irq_mask_ff, nxt_irq_mask;
  logic [23:0] mirq_ff, nxt_mirq;
  logic        irq_ff, nxt_irq;
  logic [23:0] hit;
  logic [23:0] clr;
  logic [23:0] ien;
  logic [15:0] count_vec [6];
  logic [63:0] greg_vec [6];
  logic [5:0]  cnt_wr;
  logic [3:0]  greg_wr [6];
  logic [5:0]  dir_up;
  logic        do_wr;
  logic        do_rd;
  logic [2:0]  ch_sel;
  logic [4:0]  reg_sel;
  logic [31:0] rd_val;

  function automatic logic [3:0] flag_mask(input int ch);
    flag_mask = (ch == 0 || ch == 3) ? tmr_pkg::FLAGS_4R : tmr_pkg::FLAGS_2R;
  endfunction

  function automatic logic [23:0] valid_flags();
    valid_flags = 24'h0;
    for (int c = 0; c < tmr_pkg::CH_NUM; c++) begin
      valid_flags[c*4 +: 4] = flag_mask(c);
    end
  endfunction

  for (genvar g = 0; g < tmr_pkg::CH_NUM; g++) begin : gen_ch
    localparam bit FOUR = (g == 0 || g == 3);
    chan_link_if lnk ();
    channel_counter_unit #(.UPDOWN(!FOUR)) u_cnt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .lnk     (lnk.cnt)
    );
    compare_unit #(.NREG(FOUR ? 4 : 2)) u_cmp (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .lnk          (lnk.cmp),
      .capture_mode (ctl_ff[g][tmr_pkg::CTL_CAP_LSB +: 4]),
      .buffer_en    (ctl_ff[g][tmr_pkg::CTL_BUF_LSB +: 2]),
      .capture_in   (capture_in[g*4 +: 4]),
      .wr_en        (greg_wr[g]),
      .wdata        (hwdata[15:0]),
      .greg         (greg_vec[g]),
      .hit          (hit[g*4 +: 4])
    );
    assign lnk.wr    = cnt_wr[g];
    assign lnk.wdata = hwdata[15:0];
    assign lnk.tick  = count_tick[g] & ctl_ff[g][tmr_pkg::CTL_RUN_BIT];
    assign lnk.down  = count_down[g] & ctl_ff[g][tmr_pkg::CTL_UPDN_BIT];
    assign dir_up[g] = ~lnk.down;
    assign count_vec[g] = lnk.count;
  end

  // bus: one wait state so reads see any write that just finished
  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_write = write_ff;
    nxt_word  = word_ff;
    nxt_ready = ready_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      tmr_pkg::BUS_IDLE: begin
        if (hsel && htrans[1] && ready_ff) begin
          nxt_state = tmr_pkg::BUS_DATA;
          nxt_addr  = haddr[7:0];
          nxt_write = hwrite;
          nxt_word  = (hsize == tmr_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
          nxt_ready = 1'b0;
        end
      end
      tmr_pkg::BUS_DATA: begin
        nxt_state = tmr_pkg::BUS_IDLE;
        nxt_ready = 1'b1;
        nxt_rdata = write_ff ? 32'h0000_0000 : rd_val;
      end
      default: begin
        nxt_state = tmr_pkg::BUS_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  assign do_wr   = (state_ff == tmr_pkg::BUS_DATA) && write_ff;
  assign do_rd   = (state_ff == tmr_pkg::BUS_DATA) && !write_ff;
  assign ch_sel  = addr_ff[7:5];
  assign reg_sel = addr_ff[4:0];

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_ff == tmr_pkg::OFS_IRQ_ST) begin
      rd_val[23:0] = irq_st_ff;
    end else if (addr_ff == tmr_pkg::OFS_IRQ_MASK) begin
      rd_val[23:0] = irq_mask_ff;
    end else if (ch_sel < 3'(tmr_pkg::CH_NUM)) begin
      case (reg_sel)
        tmr_pkg::OFS_STATUS: begin
          rd_val[3:0] = flag_ff[ch_sel*4 +: 4];
          rd_val[tmr_pkg::ST_ONE_BIT] = 1'b1;
          rd_val[tmr_pkg::ST_DIR_BIT] = dir_up[ch_sel];
        end
        tmr_pkg::OFS_COUNT:  rd_val[15:0] = word_ff ? count_vec[ch_sel] : 16'h0000;
        tmr_pkg::OFS_GREG_A: rd_val[15:0] = word_ff ? greg_vec[ch_sel][15:0] : 16'h0000;
        tmr_pkg::OFS_GREG_B: rd_val[15:0] = word_ff ? greg_vec[ch_sel][31:16] : 16'h0000;
        tmr_pkg::OFS_GREG_C: begin
          if (word_ff && flag_mask(32'(ch_sel)) == tmr_pkg::FLAGS_4R) begin
            rd_val[15:0] = greg_vec[ch_sel][47:32];
          end
        end
        tmr_pkg::OFS_GREG_D: begin
          if (word_ff && flag_mask(32'(ch_sel)) == tmr_pkg::FLAGS_4R) begin
            rd_val[15:0] = greg_vec[ch_sel][63:48];
          end
        end
        tmr_pkg::OFS_CTRL:   rd_val[11:0] = ctl_ff[ch_sel];
        default:             rd_val = 32'h0000_0000;
      endcase
    end
  end

  // register writes and flag bookkeeping
  always_comb begin
    cnt_wr       = 6'h00;
    nxt_irq_mask = irq_mask_ff;
    nxt_armed    = armed_ff;
    clr          = 24'h0;
    ien          = 24'h0;
    for (int c = 0; c < tmr_pkg::CH_NUM; c++) begin
      nxt_ctl[c] = ctl_ff[c];
      greg_wr[c] = 4'h0;
      ien[c*4 +: 4] = ctl_ff[c][tmr_pkg::CTL_IEN_LSB +: 4] & flag_mask(c);
      if (do_wr && ch_sel == 3'(c) && reg_sel == tmr_pkg::OFS_CTRL) begin
        nxt_ctl[c] = hwdata[11:0] &
          (flag_mask(c) == tmr_pkg::FLAGS_4R ? tmr_pkg::CTL_WMASK_4R : tmr_pkg::CTL_WMASK_2R);
      end
      if (do_wr && word_ff && ch_sel == 3'(c)) begin
        cnt_wr[c] = (reg_sel == tmr_pkg::OFS_COUNT);
        greg_wr[c][0] = (reg_sel == tmr_pkg::OFS_GREG_A);
        greg_wr[c][1] = (reg_sel == tmr_pkg::OFS_GREG_B);
        greg_wr[c][2] = (reg_sel == tmr_pkg::OFS_GREG_C) && flag_mask(c) == tmr_pkg::FLAGS_4R;
        greg_wr[c][3] = (reg_sel == tmr_pkg::OFS_GREG_D) && flag_mask(c) == tmr_pkg::FLAGS_4R;
      end
      if (ch_sel == 3'(c) && reg_sel == tmr_pkg::OFS_STATUS) begin
        // arm on read of 1, clear on written 0
        if (do_rd) begin
          nxt_armed[c*4 +: 4] = armed_ff[c*4 +: 4] | flag_ff[c*4 +: 4];
        end else if (do_wr) begin
          clr[c*4 +: 4] = armed_ff[c*4 +: 4] & ~hwdata[3:0];
          nxt_armed[c*4 +: 4] = 4'h0;
        end
      end
    end
    clr = clr | (xfer_ack & ~irq_disable_select);
    // set wins, reserved bits stay zero
    nxt_flag   = ((flag_ff & ~clr) | hit) & valid_flags();
    nxt_armed  = nxt_armed & nxt_flag;
    nxt_irq_st = irq_st_ff | (hit & valid_flags());
    if (do_wr && word_ff && addr_ff == tmr_pkg::OFS_IRQ_ST) begin
      nxt_irq_st = (irq_st_ff & ~hwdata[23:0]) | (hit & valid_flags());
    end
    if (do_wr && word_ff && addr_ff == tmr_pkg::OFS_IRQ_MASK) begin
      nxt_irq_mask = hwdata[23:0] & valid_flags();
    end
    nxt_mirq = nxt_flag & ien;
    nxt_irq  = |(nxt_irq_st & nxt_irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= tmr_pkg::BUS_IDLE;
      addr_ff     <= 8'h00;
      write_ff    <= 1'b0;
      word_ff     <= 1'b0;
      ready_ff    <= 1'b1;
      rdata_ff    <= 32'h0000_0000;
      flag_ff     <= 24'h0;
      armed_ff    <= 24'h0;
      irq_st_ff   <= 24'h0;
      irq_mask_ff <= 24'h0;
      mirq_ff     <= 24'h0;
      irq_ff      <= 1'b0;
      for (int c = 0; c < tmr_pkg::CH_NUM; c++) begin
        ctl_ff[c] <= tmr_pkg::CTL_RST;
      end
    end else begin
      state_ff    <= nxt_state;
      addr_ff     <= nxt_addr;
      write_ff    <= nxt_write;
      word_ff     <= nxt_word;
      ready_ff    <= nxt_ready;
      rdata_ff    <= nxt_rdata;
      flag_ff     <= nxt_flag;
      armed_ff    <= nxt_armed;
      irq_st_ff   <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
      mirq_ff     <= nxt_mirq;
      irq_ff      <= nxt_irq;
      ctl_ff      <= nxt_ctl;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp     = 1'b0;
  assign match_irq = mirq_ff;
  assign irq       = irq_ff;

  chk_flag_on_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(hit & valid_flags())) |=> ((flag_ff & $past(hit & valid_flags()))
                                   == $past(hit & valid_flags())))
    else $error("event did not set its flag");
  chk_clear_armed: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> (($past(flag_ff) & ~flag_ff &
               ~$past(armed_ff | (xfer_ack & ~irq_disable_select))) == 24'h0))
    else $error("flag cleared without prior read");
  chk_xfer_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(xfer_ack & ~irq_disable_select & ~hit)) |=>
      (($past(xfer_ack & ~irq_disable_select & ~hit) & flag_ff) == 24'h0))
    else $error("transfer start left flag set");
  chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (flag_ff & ~valid_flags()) == 24'h0)
    else $error("reserved flag bit set");
  chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(hit & clr & valid_flags())) |=> (|(flag_ff & $past(hit & clr & valid_flags()))))
    else $error("clear beat a setting event");
  chk_up_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (gen_ch[3].lnk.tick && !cnt_wr[3]) |=> count_vec[3] == $past(count_vec[3]) + 16'h0001)
    else $error("channel 3 did not count up");
  chk_irq_req: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 match_irq == ($past(flag_ff & ien) | ($past(hit & ien) & valid_flags())) ||
        match_irq == (flag_ff & $past(ien)))
    else $error("request does not follow flag and enable");
  chk_byte_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (do_wr && !word_ff && reg_sel == tmr_pkg::OFS_COUNT) |-> cnt_wr == 6'h00)
    else $error("byte write reached a counter");
  chk_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && htrans[1] && hreadyout) |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
endmodule

// ==== tmr_pkg.sv ====
package tmr_pkg;
  localparam int          CH_NUM        = 6;
  localparam int          EV_NUM        = 24;
  // per-channel window of 32 bytes, channel index in haddr[7:5]
  localparam logic [4:0]  OFS_STATUS    = 5'h00;
  localparam logic [4:0]  OFS_COUNT     = 5'h04;
  localparam logic [4:0]  OFS_GREG_A    = 5'h08;
  localparam logic [4:0]  OFS_GREG_B    = 5'h0C;
  localparam logic [4:0]  OFS_GREG_C    = 5'h10;
  localparam logic [4:0]  OFS_GREG_D    = 5'h14;
  localparam logic [4:0]  OFS_CTRL      = 5'h18;
  localparam logic [7:0]  OFS_IRQ_ST    = 8'hC0;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'hC4;
  // control register fields
  localparam int          CTL_CAP_LSB   = 0;
  localparam int          CTL_BUF_LSB   = 4;
  localparam int          CTL_IEN_LSB   = 6;
  localparam int          CTL_RUN_BIT   = 10;
  localparam int          CTL_UPDN_BIT  = 11;
  localparam logic [11:0] CTL_RST       = 12'h000;
  localparam logic [11:0] CTL_WMASK_4R  = 12'h7FF;
  localparam logic [11:0] CTL_WMASK_2R  = 12'hCC3;
  // status byte layout
  localparam int          ST_DIR_BIT    = 7;
  localparam int          ST_ONE_BIT    = 6;
  localparam logic [3:0]  FLAGS_4R      = 4'hF;
  localparam logic [3:0]  FLAGS_2R      = 4'h3;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] GREG_RST      = 16'hFFFF;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_type;
endpackage

// ==== xfer_ctl_model.sv ====
`timescale 1ns/10ps
module xfer_ctl_model (
  input  wire logic        hclk,       // bus clock
  input  wire logic        hresetn,    // async reset, low
  input  wire logic [23:0] match_irq,  // requests from the timer
  input  wire logic [23:0] arm,        // flags served by a transfer
  input  wire logic [23:0] select_cfg,         // disable select per transfer
  output logic      [23:0] xfer_ack,           // transfer start pulse
  output logic      [23:0] irq_disable_select  // select, valid with start only
);
  logic [23:0] irq_q_ff;
  logic [23:0] ack_ff;
  logic [23:0] select_ff;
  logic [23:0] nxt_irq_q;
  logic [23:0] nxt_ack;
  logic [23:0] nxt_select;
  always_comb begin
    nxt_irq_q = match_irq;
    nxt_ack   = match_irq & ~irq_q_ff & arm;
    // idle select shows the inverse so a stale value cannot pass
    nxt_select = (select_cfg & nxt_ack) | (~select_cfg & ~nxt_ack);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q_ff <= 24'h000000;
      ack_ff   <= 24'h000000;
      select_ff <= 24'hFFFFFF;
    end else begin
      irq_q_ff <= nxt_irq_q;
      ack_ff   <= nxt_ack;
      select_ff <= nxt_select;
    end
  end
  assign xfer_ack           = ack_ff;
  assign irq_disable_select = select_ff;
endmodule
